// *** design/adc_fmt_consts.vh ***
// Constants for the triple converter output formatter.
// Assumes inclusion by bare name from each design file that needs it.
`ifndef ADC_FMT_CONSTS_VH
`define ADC_FMT_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave.
`define REG_CONTROL_OFFSET      8'h00
`define REG_STATUS_OFFSET       8'h04

// Control register fields and reset value.
`define CTRL_SOURCE_BIT         0
`define CTRL_MODE_LSB           1
`define CTRL_MODE_MSB           3
`define CTRL_RESET_VALUE        4'h0

// Status register fields.
`define STAT_OUT_MODE_LSB       0
`define STAT_LATCHED_MODE_LSB   3
`define STAT_SYNC_BIT           6
`define STAT_PHASE_BIT          7
`define STAT_SOURCE_BIT         8

// AXI responses.
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

// Output modes.
`define MODE_444                3'h0
`define MODE_422_8FS            3'h1
`define MODE_422_PAIRED         3'h2
`define MODE_422_SPECIAL        3'h3
`define MODE_411                3'h4
`define MODE_411_SPECIAL        3'h5
`define MODE_PATTERN_1          3'h6
`define MODE_PATTERN_2          3'h7
`define MODE_RESET_VALUE        3'h0

// Fixed patterns and enable masks.
`define PATTERN_1_VALUE         8'hAA
`define PATTERN_2_VALUE         8'h55
`define OE_ALL                  8'hFF
`define OE_NONE                 8'h00
`define OE_HIGH_NIBBLE          8'hF0

// Pipeline: total latency in sample clocks, and the depth ahead of the port registers.
`define PIPE_LATENCY            5
`define PIPE_DEPTH              4

`endif

// *** design/two_flop_sync.v ***
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the bits are independent levels; no word coherency is implied.
`timescale 1ns/1ps
`default_nettype none

module two_flop_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset.
	input  wire             aclk,
	input  wire             aresetn,
	// Asynchronous levels in, synchronised levels out.
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta;

	always @(posedge aclk) begin
		if (!aresetn) begin
			meta     <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end

endmodule // two_flop_sync

`default_nettype wire

// *** design/sample_delay_line.v ***
// Fixed-depth register delay line carrying samples with their tags.
// Assumes a shift on every clock; there is no stall.
`timescale 1ns/1ps
`default_nettype none

module sample_delay_line #(
	parameter WIDTH = 8,
	parameter DEPTH = 4
) (
	// Clock and reset.
	input  wire             aclk,
	input  wire             aresetn,
	// Data in and delayed data out.
	input  wire [WIDTH-1:0] data_in,
	output wire [WIDTH-1:0] data_out
);

	reg [WIDTH-1:0] stage [0:DEPTH-1];
	genvar i;

	always @(posedge aclk) begin
		if (!aresetn) begin
			stage[0] <= {WIDTH{1'b0}};
		end else begin
			stage[0] <= data_in;
		end
	end

	generate
		for (i = 1; i < DEPTH; i = i + 1) begin : g_stage
			always @(posedge aclk) begin
				if (!aresetn) begin
					stage[i] <= {WIDTH{1'b0}};
				end else begin
					stage[i] <= stage[i-1];
				end
			end
		end
	endgenerate

	assign data_out = stage[DEPTH-1];

endmodule // sample_delay_line

`default_nettype wire

// *** design/triple_adc_output_formatter.v ***
// Output formatter of a three-channel 8-bit converter with an AXI4-Lite slave.
// Assumes step indices arrive on aclk from the quantisers; the mode pins are asynchronous.
//
// Contract
// [RQ1] Output code is the inverse of the step: step 0 gives all ones, 255 zeros.
// [RQ2] Three select bits, bit 2 most significant, pick one of eight output modes.
// [RQ3] Five clock latency; the mode travels with its samples so none is corrupted.
// [RQ4] While mode sync is low the mode logic is held in its reset state.
// [RQ5] On a mode sync rise the selects are captured and used after the latency.
// [RQ6] The controller holds each mode sync pulse at least one sample clock.
// [RQ7] Mode 0 gives each port its own channel every clock, phase marker low.
// [RQ8] Mode 2 port B alternates B and C of the even sample; port C floats.
// [RQ9] Mode 2 phase marker toggles each clock, high while port B carries B.
// [RQ10] Mode 3 port B alternates even B samples and odd C samples.
// [RQ11] In modes 0, 2 and 3 port A carries a fresh A sample every clock.
// [RQ12] Each port has an active low enable; high makes that port float.
// [RQ13] Mode 1 repeats even A twice; B holds B and C of each fourth sample.
// [RQ14] Mode 6 drives 10101010 on all ports, mode 7 its complement.
// [RQ15] Mode 3 floats port C and marks the channel B phase like mode 2.
// [RQ16] All channels are sampled together and pipelined in lockstep.
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "adc_fmt_consts.vh"

module triple_adc_output_formatter (
	// Clock and reset.
	input  wire        aclk,
	input  wire        aresetn,
	// Quantised step indices from the three channels.
	input  wire [7:0]  ch_a_step,
	input  wire [7:0]  ch_b_step,
	input  wire [7:0]  ch_c_step,
	// Mode pins.
	input  wire        mode_sync,
	input  wire        format_select_0,
	input  wire        format_select_1,
	input  wire        format_select_2,
	// Output enable pins.
	input  wire        port_a_output_enable_n,
	input  wire        port_b_output_enable_n,
	input  wire        port_c_output_enable_n,
	// Output ports with per-bit drive enables, and the phase marker, which has none.
	output reg  [7:0]  port_a_bus,
	output reg  [7:0]  port_a_bus_oe,
	output reg  [7:0]  port_b_bus,
	output reg  [7:0]  port_b_bus_oe,
	output reg  [7:0]  port_c_bus,
	output reg  [7:0]  port_c_bus_oe,
	output reg         phase_marker_out,
	// AXI4-Lite write address channel.
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data channel.
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response channel.
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address channel.
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data channel.
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// Pin synchronisers. The enables pass them too, so a port floats three clocks after
	// its enable rises; every output is registered, which rules out a combinational path.
	wire [6:0] pins_sync;
	wire       sync_level;
	wire [2:0] select_pins;
	wire [2:0] enable_n;
	reg        sync_prev;

	two_flop_sync #(
		.WIDTH    (7)
	) u_pin_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({port_c_output_enable_n, port_b_output_enable_n, port_a_output_enable_n,
		            format_select_2, format_select_1, format_select_0, mode_sync}),
		.sync_out (pins_sync)
	);

	assign sync_level  = pins_sync[0];
	assign select_pins = pins_sync[3:1];
	assign enable_n    = pins_sync[6:4];

	// Software control: bit 0 takes the mode from the register instead of the pins.
	reg  [3:0] control;
	wire [2:0] select_value;

	assign select_value = control[`CTRL_SOURCE_BIT] ?
	                      control[`CTRL_MODE_MSB:`CTRL_MODE_LSB] : select_pins; // [RQ2]

	// Mode latch and sample index, both tagged onto each sample as it enters.
	reg  [2:0] latched_mode;
	reg  [1:0] sample_idx;
	wire       sync_rise;

	assign sync_rise = sync_level & ~sync_prev; // [RQ5]

	always @(posedge aclk) begin
		if (!aresetn) begin
			sync_prev    <= 1'b0;
			latched_mode <= `MODE_RESET_VALUE;
			sample_idx   <= 2'h0;
		end else begin
			sync_prev <= sync_level;
			if (!sync_level) begin
				latched_mode <= `MODE_RESET_VALUE; // [RQ4]
				sample_idx   <= 2'h0;
			end else if (sync_rise) begin
				latched_mode <= select_value; // [RQ5]
				sample_idx   <= 2'h0;
			end else begin
				sample_idx <= sample_idx + 2'h1;
			end
		end
	end

	// Pipeline: four stages here and the port registers make five.
	wire [28:0] pipe_in;
	wire [28:0] pipe_out;
	wire [7:0]  p_a;
	wire [7:0]  p_b;
	wire [7:0]  p_c;
	wire [2:0]  p_mode;
	wire [1:0]  p_idx;

	assign pipe_in = {~ch_a_step, ~ch_b_step, ~ch_c_step, latched_mode, sample_idx}; // [RQ1]

	sample_delay_line #(
		.WIDTH    (29),
		.DEPTH    (`PIPE_DEPTH)
	) u_pipe (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.data_in  (pipe_in),
		.data_out (pipe_out)
	); // [RQ3] [RQ16]

	assign p_a    = pipe_out[28:21];
	assign p_b    = pipe_out[20:13];
	assign p_c    = pipe_out[12:5];
	assign p_mode = pipe_out[4:2];
	assign p_idx  = pipe_out[1:0];

	// Held copies of the last even sample and of the first sample of each group of four.
	reg  [7:0] hold_even_a;
	reg  [7:0] hold_even_c;
	reg  [7:0] hold_group_b;
	reg  [7:0] hold_group_c;
	wire [7:0] even_a;
	wire [7:0] even_c;
	wire [7:0] group_b;
	wire [7:0] group_c;

	assign even_a  = p_idx[0] ? hold_even_a : p_a;
	assign even_c  = p_idx[0] ? hold_even_c : p_c;
	assign group_b = (p_idx == 2'h0) ? p_b : hold_group_b;
	assign group_c = (p_idx == 2'h0) ? p_c : hold_group_c;

	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_even_a  <= 8'h00;
			hold_even_c  <= 8'h00;
			hold_group_b <= 8'h00;
			hold_group_c <= 8'h00;
		end else begin
			if (!p_idx[0]) begin
				hold_even_a <= p_a;
				hold_even_c <= p_c;
			end
			if (p_idx == 2'h0) begin
				hold_group_b <= p_b;
				hold_group_c <= p_c;
			end
		end
	end

	// Port formatting for the sample leaving the pipeline.
	reg [7:0] next_a;
	reg [7:0] next_b;
	reg [7:0] next_c;
	reg [7:0] next_oe_b;
	reg [7:0] next_oe_c;
	reg       next_phase;
	reg [3:0] nibble;

	always @* begin
		next_a     = p_a; // [RQ11]
		next_b     = p_b;
		next_c     = p_c;
		next_oe_b  = `OE_ALL;
		next_oe_c  = `OE_ALL;
		next_phase = 1'b0;
		nibble     = 4'h0;
		case (p_mode)
		`MODE_444: begin
			next_phase = 1'b0; // [RQ7]
		end
		`MODE_422_8FS: begin
			next_a     = even_a; // [RQ13]
			next_b     = p_idx[1] ? group_c : group_b;
			case (p_idx)
			2'h0: next_c = group_b;
			2'h2: next_c = group_c;
			default: next_c = even_a;
			endcase
			next_phase = (p_idx == 2'h0);
		end
		`MODE_422_PAIRED: begin
			next_b     = p_idx[0] ? hold_even_c : p_b; // [RQ8]
			next_c     = 8'h00;
			next_oe_c  = `OE_NONE;
			next_phase = ~p_idx[0]; // [RQ9]
		end
		`MODE_422_SPECIAL: begin
			next_b     = p_idx[0] ? p_c : p_b; // [RQ10]
			next_c     = 8'h00;
			next_oe_c  = `OE_NONE; // [RQ15]
			next_phase = ~p_idx[0]; // [RQ15]
		end
		`MODE_411: begin
			case (p_idx)
			2'h0: nibble = {group_b[7:6], group_c[7:6]};
			2'h1: nibble = {group_b[5:4], group_c[5:4]};
			2'h2: nibble = {group_b[3:2], group_c[3:2]};
			default: nibble = {group_b[1:0], group_c[1:0]};
			endcase
			next_b     = {nibble, 4'h0};
			next_oe_b  = `OE_HIGH_NIBBLE;
			next_c     = 8'h00;
			next_oe_c  = `OE_NONE;
			next_phase = (p_idx == 2'h0);
		end
		`MODE_411_SPECIAL: begin
			case (p_idx)
			2'h0: nibble = group_b[3:0];
			2'h1: nibble = group_b[7:4];
			2'h2: nibble = even_c[3:0];
			default: nibble = even_c[7:4];
			endcase
			next_b     = {nibble, 4'h0};
			next_oe_b  = `OE_HIGH_NIBBLE;
			next_c     = 8'h00;
			next_oe_c  = `OE_NONE;
			next_phase = (p_idx == 2'h0);
		end
		`MODE_PATTERN_1: begin
			next_a = `PATTERN_1_VALUE; // [RQ14]
			next_b = `PATTERN_1_VALUE;
			next_c = `PATTERN_1_VALUE;
		end
		default: begin
			next_a = `PATTERN_2_VALUE; // [RQ14]
			next_b = `PATTERN_2_VALUE;
			next_c = `PATTERN_2_VALUE;
		end
		endcase
	end

	// Port registers, the fifth pipeline stage.
	reg [2:0] out_mode;

	always @(posedge aclk) begin
		if (!aresetn) begin
			port_a_bus       <= 8'h00;
			port_b_bus       <= 8'h00;
			port_c_bus       <= 8'h00;
			port_a_bus_oe    <= `OE_NONE;
			port_b_bus_oe    <= `OE_NONE;
			port_c_bus_oe    <= `OE_NONE;
			phase_marker_out <= 1'b0;
			out_mode         <= `MODE_RESET_VALUE;
		end else begin
			port_a_bus       <= next_a;
			port_b_bus       <= next_b;
			port_c_bus       <= next_c;
			port_a_bus_oe    <= enable_n[0] ? `OE_NONE : `OE_ALL; // [RQ12]
			port_b_bus_oe    <= enable_n[1] ? `OE_NONE : next_oe_b; // [RQ12]
			port_c_bus_oe    <= enable_n[2] ? `OE_NONE : next_oe_c; // [RQ12]
			phase_marker_out <= next_phase;
			out_mode         <= p_mode;
		end
	end

	// AXI4-Lite slave: address and data are taken in either order, then one response.
	reg         aw_held;
	reg         w_held;
	reg  [7:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	wire [31:0] status_word;

	assign status_word = {23'h0, control[`CTRL_SOURCE_BIT], phase_marker_out, sync_level,
	                      latched_mode, out_mode};

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0;
			w_strb        <= 4'h0;
			control       <= `CTRL_RESET_VALUE;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_held       <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_held       <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr[7:2] == `REG_CONTROL_OFFSET >> 2) begin
					s_axi_bresp <= `RESP_OKAY;
					if (w_strb[0]) begin
						control <= w_data[3:0];
					end
				end else if (aw_addr[7:2] == `REG_STATUS_OFFSET >> 2) begin
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				if (s_axi_araddr[7:2] == `REG_CONTROL_OFFSET >> 2) begin
					s_axi_rdata <= {28'h0, control};
					s_axi_rresp <= `RESP_OKAY;
				end else if (s_axi_araddr[7:2] == `REG_STATUS_OFFSET >> 2) begin
					s_axi_rdata <= status_word;
					s_axi_rresp <= `RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // triple_adc_output_formatter

`default_nettype wire

// *** verif/port_pin_view.sv ***
// Far-side view of the formatter's output pins, as capture logic sees them.
// Assumes per-bit drive enables, high while the formatter drives the pin.
`timescale 1ns/1ps
`default_nettype none
module port_pin_view (
	// Formatter outputs.
	input  wire logic [7:0] bus_a,
	input  wire logic [7:0] oe_a,
	input  wire logic [7:0] bus_b,
	input  wire logic [7:0] oe_b,
	input  wire logic [7:0] bus_c,
	input  wire logic [7:0] oe_c,
	// Resolved pin levels.
	output wire logic [7:0] pin_a,
	output wire logic [7:0] pin_b,
	output wire logic [7:0] pin_c
);
	// Pins have no pull, so a released pin floats and never shows its last value.
	genvar k;
	for (k = 0; k < 8; k = k + 1) begin : g_pin
		assign pin_a[k] = oe_a[k] ? bus_a[k] : 1'bz;
		assign pin_b[k] = oe_b[k] ? bus_b[k] : 1'bz;
		assign pin_c[k] = oe_c[k] ? bus_c[k] : 1'bz;
	end
endmodule // port_pin_view
`default_nettype wire

// *** verif/formatter_checker.sv ***
// Checker for the formatter: bus handshakes, port A enable and mode reset marker.
// Assumes binding to the formatter top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module formatter_checker (
	// Clock and reset.
	input wire logic       aclk,
	input wire logic       aresetn,
	// Pins and what they steer.
	input wire logic       mode_sync,
	input wire logic       port_a_output_enable_n,
	input wire logic [7:0] port_a_bus_oe,
	input wire logic       phase_marker_out,
	// Register bus handshakes.
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Ten low edges cover both synchroniser stages and the pipeline.
	logic [3:0] low_count;
	always @(posedge aclk) begin
		if (!aresetn || mode_sync)
			low_count <= 4'h0;
		else if (low_count != 4'hF)
			low_count <= low_count + 4'h1;
	end
	sequence s_write_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// Both halves are registered first, so the response rises one edge after the taking edge.
	a_write_answer:
		assert property (s_write_taken |=> ##1 s_axi_bvalid) else $error("no write response");
	a_write_busy:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_write_return:
		assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
		else $error("write channels not ready after response");
	a_read_answer:
		assert property (s_read_taken |=> s_axi_rvalid) else $error("no read data");
	a_read_busy:
		assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_read_return:
		assert property (s_axi_rvalid && s_axi_rready |=> s_axi_arready)
		else $error("read channel not ready after data");
	a_port_a_drive:
		assert property (!port_a_output_enable_n [*5] |-> port_a_bus_oe == 8'hFF)
		else $error("port A not driven while enabled");
	a_port_a_float:
		assert property (port_a_output_enable_n [*5] |-> port_a_bus_oe == 8'h00)
		else $error("port A driven while disabled");
	a_reset_marker:
		assert property (low_count >= 4'hA |-> !phase_marker_out)
		else $error("marker high while mode held in reset");
endmodule // formatter_checker
bind triple_adc_output_formatter formatter_checker u_checker (.aclk, .aresetn, .mode_sync,
	.port_a_output_enable_n, .port_a_bus_oe, .phase_marker_out, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// *** verif/test_triple_adc_output_formatter.sv ***
// Bench: random steps, every mode by pins and mode 5 by register, enables toggled per port.
// Assumes the formatter, the pin view and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_triple_adc_output_formatter;
	logic        aclk = 0, aresetn = 0, mode_sync = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
	logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [2:0]  sel = 0, en_n = 0, lm = 0, mode_m = 0;
	logic [7:0]  ch_a_step = 0, ch_b_step = 0, ch_c_step = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, rng = 32'h58FB642D;
	logic [3:0]  s_axi_wstrb = 4'hF;
	wire  [7:0]  port_a_bus, port_a_bus_oe, port_b_bus, port_b_bus_oe, port_c_bus, port_c_bus_oe;
	wire  [7:0]  pin_a, pin_b, pin_c;
	wire  [31:0] s_axi_rdata;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire         phase_marker_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire         s_axi_rvalid;
	logic [7:0]  ha [0:2047], hb [0:2047], hc [0:2047];
	logic [2:0]  hm [0:2047], he [0:2047], hs [0:2047];
	logic [1:0]  hi [0:2047], li = 0;
	bit          hv [0:2047], hp [0:2047], src_m = 0, chk_on = 0;
	int          n = 0, fail_count = 0, checks_done = 0, p, g;
	triple_adc_output_formatter u_dut (.aclk, .aresetn, .ch_a_step, .ch_b_step, .ch_c_step,
		.mode_sync, .format_select_0(sel[0]), .format_select_1(sel[1]), .format_select_2(sel[2]),
		.port_a_output_enable_n(en_n[0]), .port_b_output_enable_n(en_n[1]),
		.port_c_output_enable_n(en_n[2]), .port_a_bus, .port_a_bus_oe, .port_b_bus, .port_b_bus_oe,
		.port_c_bus, .port_c_bus_oe, .phase_marker_out, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	port_pin_view u_view (.bus_a(port_a_bus), .oe_a(port_a_bus_oe), .bus_b(port_b_bus),
		.oe_b(port_b_bus_oe), .bus_c(port_c_bus), .oe_c(port_c_bus_oe), .pin_a, .pin_b, .pin_c);
	always #10 aclk = ~aclk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] pin(input logic [7:0] d, input logic [7:0] oe);
		for (int k = 0; k < 8; k++)
			pin[k] = oe[k] ? d[k] : 1'bz;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		chk(s_axi_bresp, er);
		s_axi_bready <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] ad, input logic [31:0] ed, mk, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		chk(s_axi_rdata & mk, ed);
		chk(s_axi_rresp, er);
		s_axi_rready <= 0;
	endtask
	// Sync stays low long enough for the mode reset to reach the ports.
	task automatic set_mode(input logic [2:0] m);
		@(posedge aclk);
		mode_sync <= 0;
		repeat (7) @(posedge aclk);
		sel <= m;
		repeat (3) @(posedge aclk);
		mode_sync <= 1;
		repeat (16) @(posedge aclk);
		en_n <= m;
		repeat (8) @(posedge aclk);
		en_n <= 0;
		repeat (16) @(posedge aclk);
	endtask
	// Model: mode and index travel with each sample; samples near a sync edge are skipped.
	always @(posedge aclk) begin
		logic [7:0] ea, eb, ec, oa, ob, oc, bg, cg;
		logic [1:0] i;
		logic [2:0] m;
		logic       ph;
		ha[n] = ch_a_step;
		hb[n] = ch_b_step;
		hc[n] = ch_c_step;
		hp[n] = mode_sync;
		hs[n] = sel;
		he[n] = en_n;
		if (n >= 5) begin
			hm[n] = lm;
			hi[n] = li;
			hv[n] = hp[n-2] == hp[n-3] && hp[n-3] == hp[n-4] && hp[n-4] == hp[n-5];
			if (!hp[n-2]) begin
				lm = 0;
				li = 0;
			end else if (!hp[n-3]) begin
				lm = src_m ? mode_m : hs[n-2];
				li = 0;
			end else
				li = li + 2'h1;
		end
		if (chk_on && hv[n-5]) begin
			p = n - 5;
			m = hm[p];
			i = hi[p];
			g = p - i;
			bg = ~hb[g];
			cg = ~hc[g];
			ea = m == 1 ? ~ha[p - i[0]] : ~ha[p];
			ec = 8'h00;
			case (m)
				0: begin
					eb = ~hb[p];
					ec = ~hc[p];
				end
				1: begin
					eb = i[1] ? cg : bg;
					ec = i[0] ? ~ha[p-1] : eb;
				end
				2: eb = i[0] ? ~hc[p-1] : ~hb[p];
				3: eb = i[0] ? ~hc[p] : ~hb[p];
				4: eb = {bg[7-2*i -: 2], cg[7-2*i -: 2], 4'h0};
				5: begin
					cg = i[1] ? ~hc[g+2] : bg;
					eb = {i[0] ? cg[7:4] : cg[3:0], 4'h0};
				end
				default: begin
					eb = m[0] ? 8'h55 : 8'hAA;
					ea = eb;
					ec = eb;
				end
			endcase
			oa = he[n-3][0] ? 8'h00 : 8'hFF;
			ob = he[n-3][1] ? 8'h00 : (m == 4 || m == 5) ? 8'hF0 : 8'hFF;
			oc = (he[n-3][2] || (m >= 2 && m <= 5)) ? 8'h00 : 8'hFF;
			chk(pin_a, pin(ea, oa));
			chk(pin_b, pin(eb, ob));
			chk(pin_c, pin(ec, oc));
			// The pattern modes leave the marker low, as mode 0 does.
			ph = (m == 1 || m == 4 || m == 5) ? i == 0 : (m == 2 || m == 3) && !i[0];
			chk(phase_marker_out, ph);
		end
		rng = xs(rng);
		ch_a_step <= rng[7:0];
		ch_b_step <= rng[15:8];
		ch_c_step <= rng[23:16];
		n++;
		if (n > 1500) begin
			fail_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		repeat (10) @(posedge aclk);
		chk_on <= 1;
		axi_rd(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
		axi_rd(8'h10, 32'h0, 32'hFFFFFFFF, 2'h2);
		axi_wr(8'h10, 32'h0000000F, 2'h2);
		// A write without its lowest byte lane must leave the control bits alone.
		s_axi_wstrb <= 4'hE;
		axi_wr(8'h00, 32'h0000000B, 2'h0);
		axi_rd(8'h00, 32'h0, 32'hFFFFFFFF, 2'h0);
		s_axi_wstrb <= 4'hF;
		for (int m = 0; m < 8; m++)
			set_mode(m[2:0]);
		axi_wr(8'h00, 32'h0000000B, 2'h0);
		src_m = 1;
		mode_m = 3'h5;
		axi_rd(8'h00, 32'h0000000B, 32'hFFFFFFFF, 2'h0);
		axi_wr(8'h04, 32'h0, 2'h0);
		set_mode(3'h2);
		axi_rd(8'h04, 32'h0000016D, 32'h0000017F, 2'h0);
		print_verdict();
	end
endmodule // test_triple_adc_output_formatter
`default_nettype wire
